/* File: pin_function_select.sv */
/*
  Pin-function select for the shared pads: each pad carries either its
  primary function (keyboard row/column or general chip select) or one
  alternate function, chosen by straps caught during reset, by the scan
  test enable, or by configuration index bits.
  Assumes index inputs come from logic on clk; pads, straps and scan
  enable come from pins and are synchronised here.
*/
`timescale 1ns/100ps
module pin_function_select
  import pin_mux_pkg::*;
#(
  parameter int DRAM_BANKS = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [STRAP_COUNT-1:0] strap_pins,
  input wire logic scan_test_enable,
  input wire logic [7:0] cfg_idx_00,
  input wire logic [7:0] cfg_idx_01,
  input wire logic [7:0] cfg_idx_02,
  input wire logic [7:0] cfg_idx_03,
  input wire logic [7:0] cfg_idx_38,
  input wire logic [7:0] cfg_idx_39,
  input wire logic [7:0] cfg_idx_3a,
  input wire logic [DRAM_BANKS-1:0] dram_bank_cfg_bit3,
  input wire drive_t prim_drive,
  input wire drive_t alt_drive,
  input wire logic [PIN_COUNT-1:0] pad_in,
  output drive_t pad_r,
  output logic [PIN_COUNT-1:0] prim_in_r,
  output logic [PIN_COUNT-1:0] alt_in_r,
  output logic [PIN_COUNT-1:0] sel_r,
  output logic boot_rom_wide_r
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic dram_pair(input logic [7:0] idx);
    dram_pair = idx[IDX0X_EXT_BIT] & idx[IDX0X_PAIR_BIT];
  endfunction

  // ------------------------------------------------------------------
  // pin inputs through synchronisers
  // ------------------------------------------------------------------
  logic [STRAP_COUNT-1:0] strap_s;
  logic [0:0] scan_s;
  logic [PIN_COUNT-1:0] pad_in_s;

  sync2 #(.WIDTH(STRAP_COUNT)) u_strap_sync (
    .clk(clk),
    .reset(1'b0),
    .d(strap_pins),
    .q(strap_s)
  );

  sync2 #(.WIDTH(1)) u_scan_sync (
    .clk(clk),
    .reset(reset),
    .d(scan_test_enable),
    .q(scan_s)
  );

  sync2 #(.WIDTH(PIN_COUNT)) u_pad_sync (
    .clk(clk),
    .reset(reset),
    .d(pad_in),
    .q(pad_in_s)
  );

  // ------------------------------------------------------------------
  // strap capture
  // ------------------------------------------------------------------
  logic [STRAP_COUNT-1:0] strap_r;

  // sampled every cycle of reset, frozen at release
  always_ff @(posedge clk) begin
    if (reset) begin
      strap_r <= strap_s;
    end
  end

  logic rom_wide;
  assign rom_wide = strap_r[STRAP_ROM_LO] & strap_r[STRAP_ROM_HI];

  always_ff @(posedge clk) begin
    if (reset) begin
      boot_rom_wide_r <= 1'b0;
    end else begin
      boot_rom_wide_r <= rom_wide;
    end
  end

  // ------------------------------------------------------------------
  // select decode
  // ------------------------------------------------------------------
  logic dram_ext;
  logic [PIN_COUNT-1:0] sel_nxt;

  assign dram_ext = dram_pair(cfg_idx_00) | dram_pair(cfg_idx_01)
                  | cfg_idx_02[IDX0X_EXT_BIT] | cfg_idx_03[IDX0X_EXT_BIT];

  always_comb begin
    sel_nxt = SEL_RESET;
    sel_nxt[PIN_ROW0] = dram_ext;
    sel_nxt[PIN_ROW1] = dram_ext;
    sel_nxt[PIN_ROW3] = dram_ext;
    sel_nxt[PIN_ROW4] = dram_ext;
    sel_nxt[PIN_ROW5] = dram_ext;
    sel_nxt[PIN_ROW6] = dram_ext;
    sel_nxt[PIN_ROW2] = |dram_bank_cfg_bit3;
    sel_nxt[PIN_ROW7] = cfg_idx_39[IDX39_SYS_BIT];
    sel_nxt[PIN_ROW8] = cfg_idx_39[IDX39_SYS_BIT];
    sel_nxt[PIN_ROW9] = cfg_idx_39[IDX39_SYS_BIT];
    sel_nxt[PIN_ROW10] = cfg_idx_39[IDX39_SYS_BIT];
    sel_nxt[PIN_ROW11] = cfg_idx_39[IDX39_SYS_BIT];
    sel_nxt[PIN_ROW12] = cfg_idx_39[IDX39_SYS_BIT];
    sel_nxt[PIN_ROW13] = rom_wide;
    sel_nxt[PIN_COL2] = cfg_idx_3a[IDX3A_IRQ34_BIT];
    sel_nxt[PIN_COL3] = cfg_idx_3a[IDX3A_IRQ34_BIT];
    sel_nxt[PIN_COL4] = cfg_idx_3a[IDX3A_IRQ57_BIT];
    sel_nxt[PIN_COL5] = cfg_idx_3a[IDX3A_IRQ57_BIT];
    sel_nxt[PIN_COL6] = cfg_idx_3a[IDX3A_IRQ57_BIT];
    sel_nxt[PIN_CS2] = strap_r[STRAP_BUF];
    sel_nxt[PIN_CS3] = strap_r[STRAP_BUF];
    sel_nxt[PIN_CS4] = strap_r[STRAP_BUF];
    sel_nxt[PIN_CS7] = cfg_idx_38[IDX38_IRQ1_BIT];
    sel_nxt[PIN_CS8] = cfg_idx_38[IDX38_IRQ0_BIT];
    // scan test parks every pad on its primary function
    if (scan_s[0]) begin
      sel_nxt = SEL_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sel_r <= SEL_RESET;
    end else begin
      sel_r <= sel_nxt;
    end
  end

  // ------------------------------------------------------------------
  // pad drive and input steering
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      pad_r.out <= PIN_RESET;
      pad_r.oe <= PIN_RESET;
    end else begin
      pad_r.out <= (sel_r & alt_drive.out) | (~sel_r & prim_drive.out);
      pad_r.oe <= (sel_r & alt_drive.oe & ~ALT_INPUT_MASK)
                | (~sel_r & prim_drive.oe);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      alt_in_r <= PIN_RESET;
      prim_in_r <= PIN_RESET;
    end else begin
      alt_in_r <= sel_r & pad_in_s;
      prim_in_r <= ~sel_r & pad_in_s;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  // strap synchroniser has no reset, so its first two samples are unknown
  a_strap_capture: assert property (@(posedge clk)
    reset ##1 reset ##1 reset |=> strap_r == $past(strap_s))
    else $error("strap not captured during reset");

  a_strap_hold: assert property (@(posedge clk)
    !reset && !$past(reset) |-> $stable(strap_r))
    else $error("strap changed after reset");

  a_sys_select: assert property (@(posedge clk) disable iff (reset)
    cfg_idx_39[IDX39_SYS_BIT] && !scan_s[0] |=> sel_r[PIN_ROW12:PIN_ROW7] == 6'h3F)
    else $error("system functions not selected");

  a_irq0_pad: assert property (@(posedge clk) disable iff (reset)
    cfg_idx_38[IDX38_IRQ0_BIT] && !scan_s[0] ##1 !reset |=> alt_in_r[PIN_CS8] == $past(pad_in_s[PIN_CS8]) && !prim_in_r[PIN_CS8])
    else $error("irq 0 not routed from pad");

  a_irq1_pad: assert property (@(posedge clk) disable iff (reset)
    cfg_idx_38[IDX38_IRQ1_BIT] && !scan_s[0] |=> ##1 !pad_r.oe[PIN_CS7])
    else $error("irq 1 pad still driven");

  a_col_irq: assert property (@(posedge clk) disable iff (reset)
    cfg_idx_3a[IDX3A_IRQ34_BIT] && !scan_s[0] |=> sel_r[PIN_COL3:PIN_COL2] == 2'h3)
    else $error("columns 2 and 3 not switched");

  a_col_irq_hi: assert property (@(posedge clk) disable iff (reset)
    !cfg_idx_3a[IDX3A_IRQ57_BIT] |=> sel_r[PIN_COL6:PIN_COL4] == 3'h0)
    else $error("columns 4 to 6 switched while clear");

  a_buf_strap: assert property (@(posedge clk) disable iff (reset)
    !scan_s[0] |=> sel_r[PIN_CS4:PIN_CS2] == {3{$past(strap_r[STRAP_BUF])}})
    else $error("buffer pads disagree with strap");

  a_rom_enable: assert property (@(posedge clk) disable iff (reset)
    rom_wide && !scan_s[0] |=> sel_r[PIN_ROW13] ##1 boot_rom_wide_r)
    else $error("wide rom enable missing");

  a_bank_cash: assert property (@(posedge clk) disable iff (reset)
    (|dram_bank_cfg_bit3) && !scan_s[0] |=> sel_r[PIN_ROW2])
    else $error("column strobe high 2 not selected");

  a_dram_ext: assert property (@(posedge clk) disable iff (reset)
    cfg_idx_02[IDX0X_EXT_BIT] && !scan_s[0] |=> sel_r[PIN_ROW6:PIN_ROW3] == 4'hF && sel_r[PIN_ROW1:PIN_ROW0] == 2'h3)
    else $error("dram extras not selected");

  a_pad_drive: assert property (@(posedge clk) disable iff (reset)
    !sel_r[PIN_ROW10] |=> pad_r.out[PIN_ROW10] == $past(prim_drive.out[PIN_ROW10]))
    else $error("primary drive not on pad");

  a_one_path: assert property (@(posedge clk) disable iff (reset)
    (alt_in_r & prim_in_r) == PIN_RESET)
    else $error("pad input reaches both functions");

  a_revert_cs8: assert property (@(posedge clk) disable iff (reset)
    !cfg_idx_38[IDX38_IRQ0_BIT] |=> !sel_r[PIN_CS8])
    else $error("chip select 8 not restored");

endmodule

/* File: pin_mux_pkg.sv */
/*
  Constants and carrier types shared by the pin-function select logic:
  pin slot numbering, configuration index bit positions, reset values.
  Assumes nothing of its surroundings.
*/
package pin_mux_pkg;

  localparam int PIN_COUNT = 24;

  // ------------------------------------------------------------------
  // pin slot numbering of the shared pads
  // ------------------------------------------------------------------
  localparam int PIN_ROW0 = 0;
  localparam int PIN_ROW1 = 1;
  localparam int PIN_ROW2 = 2;
  localparam int PIN_ROW3 = 3;
  localparam int PIN_ROW4 = 4;
  localparam int PIN_ROW5 = 5;
  localparam int PIN_ROW6 = 6;
  localparam int PIN_ROW7 = 7;
  localparam int PIN_ROW8 = 8;
  localparam int PIN_ROW9 = 9;
  localparam int PIN_ROW10 = 10;
  localparam int PIN_ROW11 = 11;
  localparam int PIN_ROW12 = 12;
  localparam int PIN_ROW13 = 13;
  localparam int PIN_COL2 = 14;
  localparam int PIN_COL3 = 15;
  localparam int PIN_COL4 = 16;
  localparam int PIN_COL5 = 17;
  localparam int PIN_COL6 = 18;
  localparam int PIN_CS2 = 19;
  localparam int PIN_CS3 = 20;
  localparam int PIN_CS4 = 21;
  localparam int PIN_CS7 = 22;
  localparam int PIN_CS8 = 23;

  // alternate functions that are inputs only: their driver stays off
  localparam logic [PIN_COUNT-1:0] ALT_INPUT_MASK = 24'hC7D300;

  // ------------------------------------------------------------------
  // configuration index bit positions
  // ------------------------------------------------------------------
  localparam int IDX38_IRQ0_BIT = 1;
  localparam int IDX38_IRQ1_BIT = 2;
  localparam int IDX39_SYS_BIT = 2;
  localparam int IDX3A_IRQ34_BIT = 1;
  localparam int IDX3A_IRQ57_BIT = 2;
  localparam int IDX0X_EXT_BIT = 7;
  localparam int IDX0X_PAIR_BIT = 3;
  localparam int BANK_COL_STROBE_HIGH_2_BIT = 3;

  // ------------------------------------------------------------------
  // strap slots and reset values
  // ------------------------------------------------------------------
  localparam int STRAP_COUNT = 3;
  localparam int STRAP_BUF = 0;
  localparam int STRAP_ROM_LO = 1;
  localparam int STRAP_ROM_HI = 2;
  localparam logic [STRAP_COUNT-1:0] STRAP_RESET = 3'h0;
  localparam logic [PIN_COUNT-1:0] SEL_RESET = 24'h000000;
  localparam logic [PIN_COUNT-1:0] PIN_RESET = 24'h000000;

  typedef struct packed {
    logic [PIN_COUNT-1:0] out;
    logic [PIN_COUNT-1:0] oe;
  } drive_t;

endpackage

/* File: sync2.sv */
/*
  Two-flop synchroniser for levels arriving from outside the clock domain.
  Assumes d is a level that stays put for at least two clock periods.
*/
`timescale 1ns/100ps
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

/* File: testbench.sv */
/*
  Self-checking bench for pin_function_select: straps caught in reset,
  scan enable, index bits and pad routing, against a model of the selects.
  Assumes pin_mux_pkg and the design files are compiled before this one.
*/
`timescale 1ns/100ps
module testbench;
  import pin_mux_pkg::*;

  typedef struct packed {
    logic [PIN_COUNT-1:0] sel;
    logic boot;
    drive_t pad;
    logic [PIN_COUNT-1:0] pin;
    logic [PIN_COUNT-1:0] ain;
  } note_t;

  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [STRAP_COUNT-1:0] strap_pins = 3'h0;
  logic scan_test_enable = 1'b0;
  logic [7:0] cfg [7] = '{default: 8'h00};
  logic [3:0] bank = 4'h0;
  drive_t prim = '0;
  drive_t alt = '0;
  logic [PIN_COUNT-1:0] pad_in = 24'h000000;
  drive_t pad_r;
  logic [PIN_COUNT-1:0] prim_in_r;
  logic [PIN_COUNT-1:0] alt_in_r;
  logic [PIN_COUNT-1:0] sel_r;
  logic boot_rom_wide_r;
  logic probe = 1'b0;
  note_t q [$];
  note_t got;
  logic [63:0] r;
  int err_count = 0;
  int checks = 0;

  always #25 clk = ~clk;

  pin_function_select #(.DRAM_BANKS(4)) dut_u (
    .clk(clk), .reset(reset), .strap_pins(strap_pins),
    .scan_test_enable(scan_test_enable),
    .cfg_idx_00(cfg[0]), .cfg_idx_01(cfg[1]), .cfg_idx_02(cfg[2]),
    .cfg_idx_03(cfg[3]), .cfg_idx_38(cfg[4]), .cfg_idx_39(cfg[5]),
    .cfg_idx_3a(cfg[6]), .dram_bank_cfg_bit3(bank),
    .prim_drive(prim), .alt_drive(alt), .pad_in(pad_in),
    .pad_r(pad_r), .prim_in_r(prim_in_r), .alt_in_r(alt_in_r),
    .sel_r(sel_r), .boot_rom_wide_r(boot_rom_wide_r)
  );

  // ------------------------------------------------------------------
  // expected outputs from latched straps, scan enable and current inputs
  // ------------------------------------------------------------------
  function automatic note_t model(input logic [2:0] st, input logic sc);
    note_t n;
    logic [PIN_COUNT-1:0] s;
    logic dr;
    s = SEL_RESET;
    dr = (cfg[0][7] & cfg[0][3]) | (cfg[1][7] & cfg[1][3]) | cfg[2][7] | cfg[3][7];
    s[12:7] = {6{cfg[5][IDX39_SYS_BIT]}};
    s[PIN_CS8] = cfg[4][IDX38_IRQ0_BIT];
    s[PIN_CS7] = cfg[4][IDX38_IRQ1_BIT];
    s[15:14] = {2{cfg[6][IDX3A_IRQ34_BIT]}};
    s[18:16] = {3{cfg[6][IDX3A_IRQ57_BIT]}};
    s[21:19] = {3{st[STRAP_BUF]}};
    s[PIN_ROW13] = st[STRAP_ROM_LO] & st[STRAP_ROM_HI];
    s[PIN_ROW2] = |bank;
    s[1:0] = {2{dr}};
    s[6:3] = {4{dr}};
    if (sc) begin
      s = SEL_RESET;
    end
    n.sel = s;
    n.boot = st[STRAP_ROM_LO] & st[STRAP_ROM_HI];
    n.pad.out = (s & alt.out) | (~s & prim.out);
    n.pad.oe = (s & alt.oe & ~ALT_INPUT_MASK) | (~s & prim.oe);
    n.pin = ~s & pad_in;
    n.ain = s & pad_in;
    return n;
  endfunction

  task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d, comparisons %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // note the expectation and let the watcher compare at the next edge
  task automatic probe_now(input note_t n);
    q.push_back(n);
    probe = 1'b1;
    @(posedge clk);
    #1 probe = 1'b0;
  endtask

  task automatic do_reset(input logic [2:0] st);
    strap_pins = st;
    reset = 1'b1;
    repeat (4) @(posedge clk);
    #1 probe_now('0);
    reset = 1'b0;
  endtask

  task automatic stim(input logic [2:0] st);
    for (int i = 0; i < 7; i++) begin
      cfg[i] = 8'($urandom());
    end
    bank = 4'($urandom());
    r = {$urandom(), $urandom()};
    prim = r[47:0];
    r = {$urandom(), $urandom()};
    alt = r[47:0];
    pad_in = 24'($urandom());
    scan_test_enable = ($urandom() % 4) == 0;
    repeat (5) @(posedge clk);
    #1 probe_now(model(st, scan_test_enable));
  endtask

  // ------------------------------------------------------------------
  // watcher: takes the oldest note whenever a result is due
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    if (probe) begin
      if (q.size() == 0) begin
        err_count++;
        $display("MISMATCH at %0t: result without a note", $time);
      end else begin
        got = q.pop_front();
        check(48'(sel_r), 48'(got.sel), "select");
        check(48'(boot_rom_wide_r), 48'(got.boot), "wide rom");
        check(pad_r, got.pad, "pad drive");
        check(48'(prim_in_r), 48'(got.pin), "primary input");
        check(48'(alt_in_r), 48'(got.ain), "alternate input");
      end
    end
  end

  initial begin
    repeat (50000) @(posedge clk);
    err_count++;
    $display("MISMATCH at %0t: run limit reached", $time);
    complete_run();
  end

  // ------------------------------------------------------------------
  // main sequence: every strap code, each followed by random traffic with the strap pins inverted
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(26487));
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      #1 do_reset(k[2:0]);
      // later strap changes must not move the selection
      strap_pins = ~k[2:0];
      for (int j = 0; j < 12; j++) begin
        stim(k[2:0]);
      end
    end
    complete_run();
  end
endmodule
